/* File: timer_pkg.sv */
// Constants shared by the eight-bit compare timer and its helpers.
package timer_pkg;
  // Register addresses on the plain register port.
  localparam logic [15:0] SERIAL_TIMER_CONTROL_ADDR = 16'hffc3;
  localparam logic [15:0] TIMER_CONTROL_ADDR = 16'hffc8;
  localparam logic [15:0] TIMER_CONTROL_STATUS_ADDR = 16'hffc9;
  localparam logic [15:0] TIME_CONSTANT_A_ADDR = 16'hffca;
  localparam logic [15:0] TIME_CONSTANT_B_ADDR = 16'hffcb;
  localparam logic [15:0] TIMER_COUNT_ADDR = 16'hffcc;
  localparam logic [15:0] IRQ_STATUS_ADDR = 16'hffe0;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hffe1;
  // Field positions in the control register.
  localparam int IRQ_ENABLE_LSB = 5;
  localparam int CLEAR_SEL_LSB = 3;
  localparam int CLOCK_SEL_LSB = 0;
  // Field positions in the control/status register.
  localparam int FLAG_LSB = 5;
  localparam int OUTPUT_SEL_LSB = 0;
  // Prescale pair select bit in the serial/timer control register.
  localparam int PRESCALE_PAIR_BIT = 0;
  // Event index inside three-bit event vectors.
  localparam int EV_WRAP = 0;
  localparam int EV_MATCH_A = 1;
  localparam int EV_MATCH_B = 2;
  // Values after reset.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [7:0] CONSTANT_RESET = 8'hff;
  localparam logic [2:0] EVENT_RESET = 3'h0;
  // Prescaler bit whose falling edge marks each divided clock.
  localparam int DIV2_BIT = 0;
  localparam int DIV8_BIT = 2;
  localparam int DIV32_BIT = 4;
  localparam int DIV64_BIT = 5;
  localparam int DIV256_BIT = 7;
  // Clock source codes.
  localparam logic [2:0] CKS_STOP0 = 3'h0;
  localparam logic [2:0] CKS_DIV_LO = 3'h1;
  localparam logic [2:0] CKS_DIV_MID = 3'h2;
  localparam logic [2:0] CKS_DIV_HI = 3'h3;
  localparam logic [2:0] CKS_STOP4 = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
  // Counter clear codes.
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_EXT = 2'h3;
  // Compare output actions.
  localparam logic [1:0] OUT_KEEP = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;
endpackage : timer_pkg

/* File: edge_if.sv */
// Edge pulses of one synchronised pin, passed between timer modules.
`timescale 1ns/1ps
interface edge_if;
  // One-cycle pulses on a rising and on a falling pin edge.
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : edge_if

/* File: pin_edge_sync.sv */
// Two-stage pin synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
module pin_edge_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Raw pin and its edge pulses.
  input wire logic pin,
  edge_if.src edges
);
  // Two synchroniser stages and one history stage.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } state_s;
  state_s r_reg;
  state_s r_next;

  // Only the second stage and the history stage are compared, never the first stage.
  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
  end

  // Synchronous reset to all zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign edges.rise = r_reg.s2 & ~r_reg.s3;
  assign edges.fall = ~r_reg.s2 & r_reg.s3;
endmodule : pin_edge_sync

/* File: tick_gen.sv */
// Count tick from the prescaled clock or the external clock pin.
`timescale 1ns/1ps
module tick_gen #(
  parameter int PRESCALE_WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Source selection.
  input wire logic [2:0] clock_sel,
  input wire logic prescale_pair_select,
  // External clock edges and resulting tick.
  edge_if.dst ext,
  output logic tick
);
  import timer_pkg::*;

  // Free-running prescaler and the registered tick.
  typedef struct packed {
    logic [PRESCALE_WIDTH-1:0] pre;
    logic tick;
  } state_s;
  state_s r_reg;
  state_s r_next;

  // True when prescaler bit k falls between two values.
  function automatic logic falls(
    input logic [PRESCALE_WIDTH-1:0] old_v,
    input logic [PRESCALE_WIDTH-1:0] new_v,
    input int k
  );
    falls = old_v[k] & ~new_v[k];
  endfunction : falls

  // Select the counting edge for the chosen source.
  always_comb begin
    r_next = r_reg;
    r_next.pre = r_reg.pre + 1'b1;
    unique case (clock_sel)
      CKS_DIV_LO: r_next.tick = prescale_pair_select ?
        falls(r_reg.pre, r_next.pre, DIV2_BIT) :
        falls(r_reg.pre, r_next.pre, DIV8_BIT);
      CKS_DIV_MID: r_next.tick = prescale_pair_select ?
        falls(r_reg.pre, r_next.pre, DIV32_BIT) :
        falls(r_reg.pre, r_next.pre, DIV64_BIT);
      CKS_DIV_HI:
        r_next.tick = falls(r_reg.pre, r_next.pre, DIV256_BIT);
      CKS_EXT_RISE: r_next.tick = ext.rise;
      CKS_EXT_FALL: r_next.tick = ext.fall;
      CKS_EXT_BOTH: r_next.tick = ext.rise | ext.fall;
      default: r_next.tick = 1'b0;
    endcase
  end

  // Synchronous reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;
endmodule : tick_gen

/* File: eight_bit_compare_timer.sv */
// Eight-bit compare timer with flags, compare output and interrupt.
//
// What this block does
// - Codes 001-011 count prescaled clock falling edges.
// - Codes 000/100 stop; 101-111 use external edges.
// - Control bits 7-5 gate the three interrupt requests.
// - Set match B flag when count equals B.
// - Flag B clears by read-as-1 then write-0.
// - Flag bits accept only 0 from software.
// - All output select bits zero disables output.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module eight_bit_compare_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // External pins.
  input wire logic ext_clock_pin,
  input wire logic ext_reset_pin,
  output logic compare_out,
  output logic compare_out_en,
  // Interrupt.
  output logic irq
);
  import timer_pkg::*;

  // Whole register state of the timer.
  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] serial_timer_control;
    logic [2:0] flags;
    logic [2:0] armed;
    logic [3:0] output_sel;
    logic [7:0] time_constant_a;
    logic [7:0] time_constant_b;
    logic [7:0] timer_count;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
    logic out;
    logic out_en;
  } state_s;
  state_s r_reg;
  state_s r_next;

  // Edge pulses of the two synchronised input pins.
  edge_if ext_clock_edges ();
  edge_if ext_reset_edges ();
  // Count tick from the selected clock source.
  logic tick;

  // Decoded fields of the control register.
  logic [2:0] clock_sel;
  logic [1:0] clear_sel;
  logic [2:0] irq_enable;
  // Events of the current cycle.
  logic match_a;
  logic match_b;
  logic wrap;
  logic match_clear;
  logic pin_clear;
  logic [2:0] events;

  // External clock pin passes two flip-flops before use.
  pin_edge_sync clock_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(ext_clock_pin),
    .edges(ext_clock_edges)
  );

  // External reset pin passes two flip-flops before use.
  pin_edge_sync reset_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(ext_reset_pin),
    .edges(ext_reset_edges)
  );

  // Prescaler and clock source selection.
  tick_gen #(
    .PRESCALE_WIDTH(8)
  ) ticker (
    .clk(clk),
    .resetn(resetn),
    .clock_sel(clock_sel),
    .prescale_pair_select(
      r_reg.serial_timer_control[PRESCALE_PAIR_BIT]),
    .ext(ext_clock_edges),
    .tick(tick)
  );

  // Next level of the compare output for one action code.
  function automatic logic out_action(
    input logic cur,
    input logic [1:0] code
  );
    unique case (code)
      OUT_LOW: out_action = 1'b0;
      OUT_HIGH: out_action = 1'b1;
      OUT_TOGGLE: out_action = ~cur;
      default: out_action = cur;
    endcase
  endfunction : out_action

  // Status flag update: clear only when armed and written 0.
  // A hardware event in the same cycle wins over the clear.
  function automatic logic [2:0] flag_update(
    input logic [2:0] cur,
    input logic [2:0] armed,
    input logic write_hit,
    input logic [2:0] wbits,
    input logic [2:0] ev
  );
    logic [2:0] kept;
    kept = cur;
    if (write_hit) begin
      kept = cur & ~(armed & ~wbits);
    end
    flag_update = kept | ev;
  endfunction : flag_update

  // Field decode of the control register.
  always_comb begin
    clock_sel = r_reg.timer_control[CLOCK_SEL_LSB +: 3];
    clear_sel = r_reg.timer_control[CLEAR_SEL_LSB +: 2];
    irq_enable = r_reg.timer_control[IRQ_ENABLE_LSB +: 3];
  end

  // Compare and wrap detection, taken on the count tick only.
  // The compare sees the value the counter holds as the tick comes.
  always_comb begin
    match_a = tick && (r_reg.timer_count == r_reg.time_constant_a);
    match_b = tick && (r_reg.timer_count == r_reg.time_constant_b);
    match_clear = ((clear_sel == CLR_MATCH_A) && match_a) ||
      ((clear_sel == CLR_MATCH_B) && match_b);
    pin_clear = (clear_sel == CLR_EXT) && ext_reset_edges.rise;
    // A clear by compare replaces the increment, so no wrap follows.
    wrap = tick && (r_reg.timer_count == 8'hff) && !match_clear;
    events = '0;
    events[EV_WRAP] = wrap;
    events[EV_MATCH_A] = match_a;
    events[EV_MATCH_B] = match_b;
  end

  // Next-state logic for counter, registers, flags and outputs.
  always_comb begin
    r_next = r_reg;
    r_next.rdata = 8'h00;

    // Counter: pin clear first, then the selected tick.
    if (pin_clear) begin
      r_next.timer_count = 8'h00;
    end else if (tick) begin
      if (match_clear) begin
        r_next.timer_count = 8'h00;
      end else begin
        r_next.timer_count = r_reg.timer_count + 8'h01;
      end
    end

    // Plain register writes; a counter write beats the tick.
    if (wr) begin
      unique case (addr)
        TIMER_CONTROL_ADDR: begin
          r_next.timer_control = wdata;
        end
        SERIAL_TIMER_CONTROL_ADDR: begin
          r_next.serial_timer_control = wdata;
        end
        TIMER_CONTROL_STATUS_ADDR: begin
          r_next.output_sel = wdata[OUTPUT_SEL_LSB +: 4];
        end
        TIME_CONSTANT_A_ADDR: begin
          r_next.time_constant_a = wdata;
        end
        TIME_CONSTANT_B_ADDR: begin
          r_next.time_constant_b = wdata;
        end
        TIMER_COUNT_ADDR: begin
          r_next.timer_count = wdata;
        end
        IRQ_MASK_ADDR: begin
          r_next.irq_mask = wdata[2:0];
        end
        default: begin
          // Unmapped or read-only address: the write is dropped.
        end
      endcase
    end

    // Flags: written 1s are ignored, armed 0s clear.
    r_next.flags = flag_update(r_reg.flags, r_reg.armed,
      wr && (addr == TIMER_CONTROL_STATUS_ADDR),
      wdata[FLAG_LSB +: 3], events);

    // Arming: a read that shows a flag at 1 arms its clear.
    // Any write to the status register uses up the arming.
    if (wr && (addr == TIMER_CONTROL_STATUS_ADDR)) begin
      r_next.armed = 3'h0;
    end else if (rd && (addr == TIMER_CONTROL_STATUS_ADDR)) begin
      r_next.armed = r_reg.armed | r_reg.flags;
    end

    // Read data, valid in the cycle after the read strobe.
    if (rd) begin
      unique case (addr)
        TIMER_CONTROL_ADDR: begin
          r_next.rdata = r_reg.timer_control;
        end
        SERIAL_TIMER_CONTROL_ADDR: begin
          r_next.rdata = r_reg.serial_timer_control;
        end
        TIMER_CONTROL_STATUS_ADDR: begin
          r_next.rdata = {r_reg.flags, 1'b0, r_reg.output_sel};
        end
        TIME_CONSTANT_A_ADDR: begin
          r_next.rdata = r_reg.time_constant_a;
        end
        TIME_CONSTANT_B_ADDR: begin
          r_next.rdata = r_reg.time_constant_b;
        end
        TIMER_COUNT_ADDR: begin
          r_next.rdata = r_reg.timer_count;
        end
        IRQ_STATUS_ADDR: begin
          r_next.rdata = {5'h00, r_reg.irq_status};
        end
        IRQ_MASK_ADDR: begin
          r_next.rdata = {5'h00, r_reg.irq_mask};
        end
        default: begin
          // Unmapped addresses read as zero.
          r_next.rdata = 8'h00;
        end
      endcase
    end

    // Interrupt status: sticky, cleared by a read of it.
    // Only requests whose enable bit is set reach it, and an
    // event in the clearing cycle stays recorded.
    if (rd && (addr == IRQ_STATUS_ADDR)) begin
      r_next.irq_status = 3'h0;
    end
    r_next.irq_status = r_next.irq_status | (events & irq_enable);

    // Level interrupt while any unmasked status bit stands.
    r_next.irq = |(r_next.irq_status & r_next.irq_mask);

    // Compare output: match A action, then match B on top of it.
    // Holding the level while disabled keeps the pin glitch free
    // when software turns the output back on.
    if (match_a) begin
      r_next.out = out_action(r_reg.out, r_reg.output_sel[1:0]);
    end
    if (match_b) begin
      r_next.out = out_action(r_next.out, r_reg.output_sel[3:2]);
    end
    r_next.out_en = |r_next.output_sel;
  end

  // Single state register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg.timer_control <= CONTROL_RESET;
      r_reg.serial_timer_control <= REG8_RESET;
      r_reg.flags <= EVENT_RESET;
      r_reg.armed <= EVENT_RESET;
      r_reg.output_sel <= 4'h0;
      r_reg.time_constant_a <= CONSTANT_RESET;
      r_reg.time_constant_b <= CONSTANT_RESET;
      r_reg.timer_count <= REG8_RESET;
      r_reg.irq_status <= EVENT_RESET;
      r_reg.irq_mask <= EVENT_RESET;
      r_reg.rdata <= REG8_RESET;
      r_reg.irq <= 1'b0;
      r_reg.out <= 1'b0;
      r_reg.out_en <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign rdata = r_reg.rdata;
  assign irq = r_reg.irq;
  assign compare_out = r_reg.out;
  assign compare_out_en = r_reg.out_en;
endmodule : eight_bit_compare_timer

/* File: timer_monitor.sv */
// Port-level checker for the eight-bit compare timer.
`timescale 1ns/1ps
module timer_monitor
  import timer_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Pins and interrupt.
  input wire logic ext_clock_pin,
  input wire logic ext_reset_pin,
  input wire logic compare_out,
  input wire logic compare_out_en,
  input wire logic irq
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A write to one address followed at once by a read of it.
  sequence wr_rd(logic [15:0] a);
    (wr && addr == a) ##1 (rd && addr == a);
  endsequence
  // A cycle with no write to the control/status register.
  sequence no_status_wr;
    !(wr && addr == TIMER_CONTROL_STATUS_ADDR);
  endsequence

  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside its slot");
  a_unmapped_zero: assert property (rd && addr == 16'h0000
    |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  a_status_bit4: assert property (rd && addr == TIMER_CONTROL_STATUS_ADDR
    |=> rdata[4] == 1'b0)
    else $error("status bit 4 read as one");
  a_ctrl_readback: assert property (wr_rd(TIMER_CONTROL_ADDR)
    |=> rdata == $past(wdata, 2))
    else $error("control register lost written value");
  a_const_readback: assert property (wr_rd(TIME_CONSTANT_B_ADDR)
    |=> rdata == $past(wdata, 2))
    else $error("constant B lost written value");
  // Enable follows the select field within two cycles of the write.
  a_out_disabled: assert property (
    (wr && addr == TIMER_CONTROL_STATUS_ADDR && wdata[3:0] == 4'h0)
    ##1 no_status_wr |=> !compare_out_en)
    else $error("output enabled with select field zero");
  a_out_enabled: assert property (
    (wr && addr == TIMER_CONTROL_STATUS_ADDR && wdata[3:0] != 4'h0)
    ##1 no_status_wr |=> compare_out_en)
    else $error("output not enabled with select field set");
  a_irq_masked: assert property (
    (wr && addr == IRQ_MASK_ADDR && wdata[2:0] == 3'h0)
    ##1 !(wr && addr == IRQ_MASK_ADDR) |=> !irq)
    else $error("interrupt raised with all sources masked");
endmodule : timer_monitor

/* File: ext_pins_model.sv */
// Model of the external count clock and counter clear pins.
`timescale 1ns/1ps
module ext_pins_model #(
  parameter int HOLD_CYCLES = 3
) (
  // System clock that paces the pin edges.
  input wire logic clk,
  // Pins driven toward the timer.
  output logic ext_clock_pin,
  output logic ext_reset_pin
);
  // Both pins idle low between pulses.
  initial begin
    ext_clock_pin = 1'b0;
    ext_reset_pin = 1'b0;
  end

  // Each level is held above the two-clock minimum, so no edge is lost.
  task automatic clock_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) ext_clock_pin <= 1'b1;
      repeat (HOLD_CYCLES) @(posedge clk);
      ext_clock_pin <= 1'b0;
      repeat (HOLD_CYCLES - 1) @(posedge clk);
    end
  endtask : clock_pulses

  // One clear pulse; only its rising edge should clear the counter.
  task automatic reset_pulse();
    @(posedge clk) ext_reset_pin <= 1'b1;
    repeat (HOLD_CYCLES) @(posedge clk);
    ext_reset_pin <= 1'b0;
  endtask : reset_pulse
endmodule : ext_pins_model

/* File: eight_bit_compare_timer_bench.sv */
// Self-checking bench for the eight-bit compare timer.
`timescale 1ns/1ps
module eight_bit_compare_timer_bench;
  import timer_pkg::*;
  // One register row: address, write or not, data, expected read.
  typedef struct {
    logic [15:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;
  // Ceiling well above the few thousand cycles the tests need.
  localparam int LIMIT = 6000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic ext_clock_pin;
  logic ext_reset_pin;
  logic compare_out;
  logic compare_out_en;
  logic irq;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] v;
  logic [7:0] v0;
  // Reset values first, then plain writes; the clock stays stopped.
  row_s rows [20] = '{
    '{16'hffc8, 1'b0, 8'h00, 8'h00}, '{16'hffc9, 1'b0, 8'h00, 8'h00},
    '{16'hffca, 1'b0, 8'h00, 8'hff}, '{16'hffcb, 1'b0, 8'h00, 8'hff},
    '{16'hffcc, 1'b0, 8'h00, 8'h00}, '{16'hffe0, 1'b0, 8'h00, 8'h00},
    '{16'hffe1, 1'b0, 8'h00, 8'h00}, '{16'hffc3, 1'b0, 8'h00, 8'h00},
    '{16'hffc8, 1'b1, 8'ha4, 8'ha4}, '{16'hffca, 1'b1, 8'h3c, 8'h3c},
    '{16'hffcb, 1'b1, 8'hc3, 8'hc3}, '{16'hffcc, 1'b1, 8'h42, 8'h42},
    '{16'hffc3, 1'b1, 8'h01, 8'h01}, '{16'hffe1, 1'b1, 8'h05, 8'h05},
    '{16'hffe0, 1'b1, 8'h07, 8'h00}, '{16'h0000, 1'b1, 8'h55, 8'h00},
    '{16'hffc9, 1'b1, 8'h0f, 8'h0f}, '{16'hffc9, 1'b1, 8'he0, 8'h00},
    '{16'hffe1, 1'b1, 8'h00, 8'h00}, '{16'hffc8, 1'b1, 8'h00, 8'h00}};
  // Prescaler cases: code, pair select, counts expected in 256 cycles.
  logic [2:0] pcode [8] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h0, 3'h4};
  logic ppair [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [7:0] pexp [8] = '{8'h20, 8'h80, 8'h04, 8'h08, 8'h01, 8'h01,
    8'h00, 8'h00};

  eight_bit_compare_timer dut_u (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_clock_pin(ext_clock_pin), .ext_reset_pin(ext_reset_pin),
    .compare_out(compare_out), .compare_out_en(compare_out_en), .irq(irq));
  ext_pins_model pin_u (.clk(clk), .ext_clock_pin(ext_clock_pin),
    .ext_reset_pin(ext_reset_pin));

  // 50 MHz system clock.
  always #10 clk = ~clk;

  // Cuts a hang short; a run past the ceiling counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      wrap_up();
    end
  end

  // Compares one value and counts it.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe.
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Write strobe with a read of the same address right behind it.
  // This is the only place the port sees strobes with no gap.
  task automatic wr_then_rd(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, d);
  endtask : wr_then_rd

  // Lets pin edges pass the synchroniser before a read.
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      chk(v, rows[i].e);
    end
    chk({7'h00, compare_out_en}, 8'h00);
    // Back-to-back strobes; the control value keeps the timer stopped.
    wr_then_rd(TIMER_CONTROL_ADDR, 8'h04);
    wr_then_rd(TIME_CONSTANT_B_ADDR, 8'hc3);
    $display("test registers done");
    // Reads spaced exactly 256 cycles apart see a fixed increment.
    for (int i = 0; i < 8; i++) begin
      wr_reg(SERIAL_TIMER_CONTROL_ADDR, {7'h00, ppair[i]});
      wr_reg(TIMER_CONTROL_ADDR, {5'h00, pcode[i]});
      rd_reg(TIMER_COUNT_ADDR, v0);
      repeat (254) @(posedge clk);
      rd_reg(TIMER_COUNT_ADDR, v);
      chk(v - v0, pexp[i]);
    end
    $display("test prescaler done");
    // External edges: rising, falling, then both.
    for (int i = 5; i < 8; i++) begin
      wr_reg(TIMER_CONTROL_ADDR, 8'(i));
      wr_reg(TIMER_COUNT_ADDR, 8'h00);
      pin_u.clock_pulses(5);
      settle();
      rd_reg(TIMER_COUNT_ADDR, v);
      chk(v, (i == 7) ? 8'h0a : 8'h05);
    end
    $display("test external clock done");
    // Clear stale flags by read then write 0, with B driving output high.
    rd_reg(TIMER_CONTROL_STATUS_ADDR, v);
    wr_reg(TIMER_CONTROL_STATUS_ADDR, 8'h08);
    wr_reg(TIME_CONSTANT_B_ADDR, 8'h0a);
    wr_reg(IRQ_MASK_ADDR, 8'h04);
    wr_reg(TIMER_COUNT_ADDR, 8'h00);
    wr_reg(TIMER_CONTROL_ADDR, 8'h95);
    pin_u.clock_pulses(11);
    settle();
    rd_reg(TIMER_COUNT_ADDR, v);
    chk(v, 8'h00);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, compare_out}, 8'h01);
    // A write without a prior read of the flag must not clear it.
    wr_reg(TIMER_CONTROL_STATUS_ADDR, 8'h08);
    rd_reg(TIMER_CONTROL_STATUS_ADDR, v);
    chk(v, 8'h88);
    wr_reg(TIMER_CONTROL_STATUS_ADDR, 8'h00);
    rd_reg(TIMER_CONTROL_STATUS_ADDR, v);
    chk(v, 8'h00);
    chk({7'h00, compare_out_en}, 8'h00);
    rd_reg(IRQ_STATUS_ADDR, v);
    chk(v, 8'h04);
    @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    $display("test match b done");
    // Wrap from all ones, then a clear from the reset pin.
    wr_reg(TIMER_COUNT_ADDR, 8'hff);
    wr_reg(TIMER_CONTROL_ADDR, 8'h1d);
    pin_u.clock_pulses(3);
    settle();
    rd_reg(TIMER_COUNT_ADDR, v);
    chk(v, 8'h02);
    rd_reg(TIMER_CONTROL_STATUS_ADDR, v);
    chk(v, 8'h20);
    pin_u.reset_pulse();
    settle();
    rd_reg(TIMER_COUNT_ADDR, v);
    chk(v, 8'h00);
    $display("test wrap and pin clear done");
    wrap_up();
  end
endmodule : eight_bit_compare_timer_bench

bind eight_bit_compare_timer timer_monitor mon_u (.clk(clk),
  .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .ext_clock_pin(ext_clock_pin),
  .ext_reset_pin(ext_reset_pin), .compare_out(compare_out),
  .compare_out_en(compare_out_en), .irq(irq));
